// ===== dv/tb.sv
// Self-checking testbench of the tile status register bank.
`timescale 1ns/1ns
module tb;
  logic        clk_sys;
  logic        nrst = 1'b0;
  logic        ps_rd;
  logic        ps_wr;
  logic [7:0]  ps_num;
  logic [31:0] ps_wdata;
  logic        ps_ack;
  logic [31:0] ps_rdata;
  logic        ev_take = 1'b0;
  logic [15:0] ev_vector = 16'h0000;
  logic        ev_target_valid;
  logic [31:0] ev_target;
  logic [7:0]  thread_active = 8'h00;
  logic [7:0]  thread_paused = 8'h00;
  logic        rgmii_enable;
  logic        rgmii_txc;
  logic [7:0]  rgmii_tx_delay;
  logic        lp_div_apply;
  logic        usb_utmi_sel;
  logic        ulpi_enable;
  int          err_count = 0;
  int          checks = 0;

  // Design and core model.
  tsrb_bank u_dut (.clk_sys(clk_sys), .nrst(nrst), .ps_rd(ps_rd), .ps_wr(ps_wr),
    .ps_num(ps_num), .ps_wdata(ps_wdata), .ps_ack(ps_ack), .ps_rdata(ps_rdata),
    .startup_state(32'h1234_5678), .memory_capacity(32'h0002_0003),
    .osc_counts(64'h4444_3333_2222_1111), .ev_take(ev_take), .ev_vector(ev_vector),
    .ev_target_valid(ev_target_valid), .ev_target(ev_target),
    .thread_active(thread_active), .thread_paused(thread_paused),
    .rgmii_enable(rgmii_enable), .rgmii_txc(rgmii_txc), .rgmii_tx_delay(rgmii_tx_delay),
    .lp_div_apply(lp_div_apply), .usb_utmi_sel(usb_utmi_sel), .ulpi_enable(ulpi_enable));
  tsrb_core_model u_core (.clk_sys(clk_sys), .nrst(nrst), .ps_rd(ps_rd), .ps_wr(ps_wr),
    .ps_num(ps_num), .ps_wdata(ps_wdata), .ps_ack(ps_ack), .ps_rdata(ps_rdata));

  // 50 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Compares and counts; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  // Write one register and expect the single-cycle answer.
  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    logic [31:0] r;
    logic        a;
    u_core.access(1'b1, {n, 8'h0B}, d, r, a);
    chk({31'h0, a}, 32'h1);
  endtask : wr

  // Read one register and compare with the expected word.
  task automatic rd(input logic [7:0] n, input logic [31:0] e);
    logic [31:0] r;
    logic        a;
    u_core.access(1'b0, {n, 8'h0B}, 32'h0, r, a);
    chk({31'h0, a}, 32'h1);
    chk(r, e);
  endtask : rd

  // Lets the registered outputs follow an input change.
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // Holds reset for five cycles, then checks reset values.
  task automatic t_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h00, 32'h0004_0000);
    rd(8'h01, 32'h0000_0000);
    rd(8'h02, 32'h0000_0000);
    chk({20'h0, rgmii_tx_delay, rgmii_enable, rgmii_txc, usb_utmi_sel, ulpi_enable}, 32'h0);
  endtask : t_reset

  // Writable masks, reserved bits and the control output fields.
  task automatic t_fields();
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'hFFFF_FFFC);
    wr(8'h01, 32'hFFFF_FFFF);
    rd(8'h01, 32'hFFFC_0000);
    wr(8'h02, 32'hFFFF_FEFF);
    rd(8'h02, 32'h03FF_FE36);
    chk({21'h0, rgmii_tx_delay, rgmii_enable, usb_utmi_sel, ulpi_enable}, 32'h7FB);
    wr(8'h02, 32'h0000_0104);
    chk({29'h0, rgmii_enable, usb_utmi_sel, ulpi_enable}, 32'h6);
    wr(8'h02, 32'h0000_0002);
    chk({29'h0, rgmii_enable, usb_utmi_sel, ulpi_enable}, 32'h1);
  endtask : t_fields

  // Read-only, storage and unmapped numbers.
  task automatic t_others();
    wr(8'h03, 32'hFFFF_FFFF);
    rd(8'h03, 32'h1234_5678);
    rd(8'h0C, 32'h0002_0000);
    for (int k = 0; k < 4; k++) begin
      rd(8'h07 + 8'(k), {16'h0, {4{4'(k + 1)}}});
    end
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_0000);
    wr(8'h05, 32'hA5A5_5A5A);
    rd(8'h05, 32'hA5A5_5A5A);
  endtask : t_others

  // Jump target takes the upper half from the vector base.
  task automatic t_event();
    wr(8'h01, 32'hABCD_1234);
    @(posedge clk_sys);
    ev_take   <= 1'b1;
    ev_vector <= 16'h5A3C;
    @(posedge clk_sys);
    ev_take   <= 1'b0;
    #1;
    chk({31'h0, ev_target_valid}, 32'h1);
    chk(ev_target, 32'hABCC_5A3C);
    @(posedge clk_sys);
    #1;
    chk({31'h0, ev_target_valid}, 32'h0);
    chk(ev_target, 32'hABCC_5A3C);
  endtask : t_event

  // Transmit clock for a wanted divide of five.
  task automatic t_txclk();
    int h;
    int l;
    h = 0;
    l = 0;
    wr(8'h02, 32'h0000_0900);
    for (int i = 0; i < 20 && rgmii_txc !== 1'b0; i++) settle();
    for (int i = 0; i < 20 && rgmii_txc !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    while (rgmii_txc === 1'b1 && h < 20) begin
      @(posedge clk_sys);
      #1;
      h++;
    end
    while (rgmii_txc === 1'b0 && l < 20) begin
      @(posedge clk_sys);
      #1;
      l++;
    end
    chk(32'(h), 32'd3);
    chk(32'(h + l), 32'd5);
  endtask : t_txclk

  // Low-power divider in static and dynamic mode.
  task automatic t_lowpower();
    @(posedge clk_sys);
    thread_active <= 8'h03;
    wr(8'h02, 32'h0000_0010);
    settle();
    chk({31'h0, lp_div_apply}, 32'h1);
    wr(8'h02, 32'h0000_0030);
    settle();
    chk({31'h0, lp_div_apply}, 32'h0);
    @(posedge clk_sys);
    thread_paused <= 8'h03;
    settle();
    chk({31'h0, lp_div_apply}, 32'h1);
    wr(8'h02, 32'h0000_0020);
    settle();
    chk({31'h0, lp_div_apply}, 32'h0);
  endtask : t_lowpower

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence, with a second reset at the end.
  initial begin
    t_reset();
    t_fields();
    t_others();
    t_event();
    t_txclk();
    t_lowpower();
    t_reset();
    complete_run();
  end

  // Cuts a hang short.
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule : tb

// ===== dv/tsrb_core_model.sv
// Processor core model that issues status-register reads and writes.
`timescale 1ns/1ns
module tsrb_core_model (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Status-register port towards the bank.
  output logic             ps_rd,
  output logic             ps_wr,
  output logic [7:0]       ps_num,
  output logic [31:0]      ps_wdata,
  input  wire logic        ps_ack,
  input  wire logic [31:0] ps_rdata
);
  // The port is idle from time zero.
  initial begin
    ps_rd    = 1'b0;
    ps_wr    = 1'b0;
    ps_num   = 8'h00;
    ps_wdata = 32'h0000_0000;
  end

  // One whole-word access by resource identifier; the answer stands one cycle after the take.
  task automatic access(input logic wr, input logic [15:0] res, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ack);
    @(posedge clk_sys);
    ps_num   <= res[15:8];
    ps_rd    <= ~wr;
    ps_wr    <= wr;
    ps_wdata <= wd;
    @(posedge clk_sys);
    ps_rd    <= 1'b0;
    ps_wr    <= 1'b0;
    // Released lines show no stale value.
    ps_num   <= ~res[15:8];
    ps_wdata <= ~wd;
    #1;
    ack = ps_ack;
    rd  = ps_rdata;
  endtask : access
endmodule : tsrb_core_model

// ===== rtl/tsrb_bank.sv
// Tile status register bank with tile control outputs and vector target forming.
`timescale 1ns/1ns
module tsrb_bank (
  // Clock and synchronous active-low reset.
  input  wire logic                           clk_sys,
  input  wire logic                           nrst,
  // Status-register port from the processor core.
  input  wire logic                           ps_rd,
  input  wire logic                           ps_wr,
  input  wire logic [tsrb_pkg::NUM_W-1:0]     ps_num,
  input  wire logic [31:0]                    ps_wdata,
  output logic                                ps_ack,
  output logic [31:0]                         ps_rdata,
  // Read-only state supplied by the rest of the tile.
  input  wire logic [31:0]                    startup_state,
  input  wire logic [31:0]                    memory_capacity,
  input  wire logic [4*tsrb_pkg::OSC_W-1:0]   osc_counts,
  // Event and interrupt jump target forming.
  input  wire logic                           ev_take,
  input  wire logic [tsrb_pkg::HALF_W-1:0]    ev_vector,
  output logic                                ev_target_valid,
  output logic [31:0]                         ev_target,
  // Thread state for the dynamic clock divider mode.
  input  wire logic [tsrb_pkg::THREADS-1:0]   thread_active,
  input  wire logic [tsrb_pkg::THREADS-1:0]   thread_paused,
  // Tile control outputs.
  output logic                                rgmii_enable,
  output logic                                rgmii_txc,
  output logic [7:0]                          rgmii_tx_delay,
  output logic                                lp_div_apply,
  output logic                                usb_utmi_sel,
  output logic                                ulpi_enable
);

  // Keeping all state in one struct means a single clocked process owns every
  // flip-flop, so no register can end up with a second driver by accident.
  // Every piece of state of the bank, registered together.
  typedef struct packed {
    logic [31:0]                                mem_base;  // Memory start word.
    logic [31:0]                                vec_base;  // Event vector high half.
    logic [31:0]                                ctrl;      // Tile control.
    logic [tsrb_pkg::PLAIN_N-1:0][31:0]         plain;     // Plain storage.
    logic [tsrb_pkg::DIV_W-1:0]                 div_cnt;   // Transmit clock counter.
    logic                                       txc;       // Transmit clock level.
    logic                                       lp_on;     // Divided clock applied.
    logic                                       ack;       // Access answered.
    logic [31:0]                                rdata;     // Read answer.
    logic                                       tgt_vld;   // Jump target valid.
    logic [31:0]                                tgt;       // Jump target.
  } tsrb_state_s;

  tsrb_state_s st;       // Current state.
  tsrb_state_s next_st;  // Next state.

  // One hit flag per plain storage register.
  logic [tsrb_pkg::PLAIN_N-1:0] plain_hit;

  // Only the first number of each debug range is decoded; the other numbers of
  // a range fall through to the unmapped case and read as zero.
  // Decode of each plain storage register number.
  genvar gi;
  generate
    for (gi = 0; gi < tsrb_pkg::PLAIN_N; gi++) begin : g_plain
      assign plain_hit[gi] = (ps_num == tsrb_pkg::PLAIN_NUM[gi]);
    end
  endgenerate

  // Divider field and its half, taken from the control register.
  logic [tsrb_pkg::DIV_W-1:0] div_val;
  logic [tsrb_pkg::DIV_W-1:0] div_half;
  // Set when every active thread is paused.
  logic                       all_paused;

  // A thread that is not active never blocks the dynamic divider, so a tile
  // with no active threads counts as fully paused.
  // Field extraction and thread test.
  always_comb begin
    div_val    = st.ctrl[tsrb_pkg::TX_DIV_HI:tsrb_pkg::TX_DIV_LO];
    div_half   = div_val >> 1;
    all_paused = ((thread_active & ~thread_paused) == '0);
  end

  // Reads and writes are answered one edge after they are taken. A read and a
  // write in the same cycle store the write and return the value held before it.
  // Next-state logic of the whole bank.
  always_comb begin
    logic [31:0] rd;   // Read value under assembly.
    logic [7:0]  oidx; // Index of an oscillator count register.
    rd      = 32'h0000_0000;
    oidx    = 8'h00;
    next_st = st;
    next_st.ack     = ps_rd | ps_wr;
    next_st.tgt_vld = ev_take;
    // Writes keep only the writable bits of each register.
    if (ps_wr) begin
      if (ps_num == tsrb_pkg::MEMORY_START_WORD) begin
        next_st.mem_base = ps_wdata & tsrb_pkg::MEM_BASE_MASK;
      end
      if (ps_num == tsrb_pkg::EVENT_VECTOR_HIGH) begin
        next_st.vec_base = ps_wdata & tsrb_pkg::VEC_BASE_MASK;
      end
      if (ps_num == tsrb_pkg::TILE_CONTROL) begin
        next_st.ctrl = ps_wdata & tsrb_pkg::CTRL_MASK;
      end
      for (int i = 0; i < tsrb_pkg::PLAIN_N; i++) begin
        if (plain_hit[i]) begin
          next_st.plain[i] = ps_wdata;
        end
      end
    end
    // The multiplexer looks at the number alone; the answer is gated by the read
    // strobe below so that idle cycles return zero.
    // Read multiplexer; unmapped numbers read as zero.
    case (ps_num)
      tsrb_pkg::MEMORY_START_WORD: begin
        rd = st.mem_base;
      end
      tsrb_pkg::EVENT_VECTOR_HIGH: begin
        rd = st.vec_base;
      end
      tsrb_pkg::TILE_CONTROL: begin
        rd = st.ctrl;
      end
      tsrb_pkg::STARTUP_STATE: begin
        rd = startup_state;
      end
      tsrb_pkg::MEMORY_CAPACITY: begin
        rd = memory_capacity & tsrb_pkg::MEM_BASE_MASK;
      end
      default: begin
        // Oscillator counts occupy four numbers in a row.
        if (ps_num >= tsrb_pkg::OSC_COUNT_FIRST && ps_num <= tsrb_pkg::OSC_COUNT_LAST) begin
          oidx = ps_num - tsrb_pkg::OSC_COUNT_FIRST;
          rd   = {16'h0000, osc_counts[oidx[1:0]*tsrb_pkg::OSC_W +: tsrb_pkg::OSC_W]};
        end
        for (int i = 0; i < tsrb_pkg::PLAIN_N; i++) begin
          if (plain_hit[i]) begin
            rd = st.plain[i];
          end
        end
      end
    endcase
    // The answer carries the contents only for a read.
    next_st.rdata = ps_rd ? rd : 32'h0000_0000;
    // Jump target: high half from the vector base, low half from the event.
    if (ev_take) begin
      next_st.tgt = {st.vec_base[31:tsrb_pkg::HALF_W], ev_vector};
    end
    // The counter runs from zero up to the divider value, so the clock period is
    // the divider value plus one cycles; a divider below the counter restarts it.
    // Transmit clock counter; it restarts after reaching the divider.
    if (!st.ctrl[tsrb_pkg::RGMII_EN_BIT]) begin
      next_st.div_cnt = '0;
      next_st.txc     = 1'b0;
    end else begin
      if (st.div_cnt >= div_val) begin
        next_st.div_cnt = '0;
      end else begin
        next_st.div_cnt = st.div_cnt + 1'b1;
      end
      // A zero divider makes rise and fall coincide, so the clock toggles.
      if (st.div_cnt == div_val && st.div_cnt == div_half) begin
        next_st.txc = ~st.txc;
      end else if (st.div_cnt == div_val) begin
        next_st.txc = 1'b1;
      end else if (st.div_cnt == div_half) begin
        next_st.txc = 1'b0;
      end
    end
    // Low-power divider: static mode always, dynamic mode while all paused.
    if (!st.ctrl[tsrb_pkg::LP_DIV_BIT]) begin
      next_st.lp_on = 1'b0;
    end else if (st.ctrl[tsrb_pkg::DYN_MODE_BIT]) begin
      next_st.lp_on = all_paused;
    end else begin
      next_st.lp_on = 1'b1;
    end
  end

  // Only the three decoded registers have documented reset values; the plain
  // storage, counter and answer flops all clear to zero as well.
  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st          <= '0;
      st.mem_base <= tsrb_pkg::MEM_BASE_RESET;
      st.vec_base <= tsrb_pkg::VEC_BASE_RESET;
      st.ctrl     <= tsrb_pkg::CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Each output is a flip-flop or a slice of one, so no decode glitch reaches
  // the pins that leave the bank.
  // Outputs taken straight from state flip-flops.
  assign ps_ack          = st.ack;
  assign ps_rdata        = st.rdata;
  assign ev_target_valid = st.tgt_vld;
  assign ev_target       = st.tgt;
  assign rgmii_enable    = st.ctrl[tsrb_pkg::RGMII_EN_BIT];
  assign rgmii_txc       = st.txc;
  assign rgmii_tx_delay  = st.ctrl[tsrb_pkg::TX_DELAY_HI:tsrb_pkg::TX_DELAY_LO];
  assign lp_div_apply    = st.lp_on;
  assign usb_utmi_sel    = st.ctrl[tsrb_pkg::UTMI_SEL_BIT];
  assign ulpi_enable     = st.ctrl[tsrb_pkg::ULPI_EN_BIT];

  // The checks watch internal state as well as ports so that a mask or decode
  // slip is caught at the register itself, not only at the next read.
  // Checks run on the system clock and rest during reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Memory base has its reset value on the first cycle out of reset.
  mem_base_reset_a: assert property ($rose(nrst) |-> st.mem_base == 32'h0004_0000)
    else $error("Memory base wrong after reset.");

  // Reserved memory base bits never set.
  mem_base_rsvd_a: assert property (st.mem_base[1:0] == 2'b00)
    else $error("Memory base reserved bits set.");

  // A write to the memory base lands with low bits cleared.
  mem_base_write_a: assert property (ps_wr && ps_num == 8'h00
    |=> st.mem_base == ($past(ps_wdata) & 32'hFFFF_FFFC))
    else $error("Memory base write lost.");

  // Vector base write keeps only the top fourteen bits.
  vec_base_write_a: assert property (ps_wr && ps_num == 8'h01
    |=> st.vec_base == {$past(ps_wdata[31:18]), 18'h00000})
    else $error("Vector base write wrong.");

  // Jump target combines vector base and event vector.
  jump_target_a: assert property (ev_take |=> ev_target_valid
    && ev_target == {$past(st.vec_base[31:16]), $past(ev_vector)})
    else $error("Jump target formed wrongly.");

  // Control write stores only writable bits.
  ctrl_write_a: assert property (ps_wr && ps_num == 8'h02
    |=> st.ctrl == ($past(ps_wdata) & 32'h03FF_FF36))
    else $error("Control write mask wrong.");

  // A tile control read is answered on the next edge with its contents.
  read_answer_a: assert property (ps_rd && !ps_wr && ps_num == 8'h02
    |=> ps_ack && ps_rdata == $past(st.ctrl))
    else $error("Status read answer wrong.");

  // Transmit clock rises one edge after the counter meets the divider.
  txc_rise_a: assert property (rgmii_enable && $stable(st.ctrl)
    && st.div_cnt == div_val && div_val != div_half |=> rgmii_txc)
    else $error("Transmit clock missed its rise.");

  // Transmit clock falls one edge after the counter meets half the divider.
  txc_fall_a: assert property (rgmii_enable && $stable(st.ctrl)
    && st.div_cnt == div_half && div_val != div_half |=> !rgmii_txc)
    else $error("Transmit clock missed its fall.");

  // Static mode keeps the divider applied one edge on.
  lp_static_a: assert property (st.ctrl[4] && !st.ctrl[5] ##1 $stable(st.ctrl)
    |-> lp_div_apply)
    else $error("Static divider not applied.");

  // Dynamic mode applies the divider only while all active threads pause.
  lp_dynamic_a: assert property (st.ctrl[4] && st.ctrl[5]
    |=> lp_div_apply == $past(all_paused))
    else $error("Dynamic divider wrong.");

  // Divider off keeps it released.
  lp_off_a: assert property (!st.ctrl[4] |=> !lp_div_apply)
    else $error("Divider applied while disabled.");

  // Register port answer and write checks.

  // Every cycle answers exactly the requests of the cycle before.
  ack_pulse_a: assert property (1'b1 |=> ps_ack == ($past(ps_rd) | $past(ps_wr)))
    else $error("Access answer pulse wrong.");

  // Read data is zero when no read was taken.
  rdata_idle_a: assert property (!ps_rd |=> ps_rdata == 32'h0000_0000)
    else $error("Read data not zero when idle.");

  // A read together with a write returns the value held before the write.
  rd_wr_same_a: assert property (ps_rd && ps_wr && ps_num == 8'h02
    |=> ps_rdata == $past(st.ctrl))
    else $error("Read with write answer wrong.");

  // Memory base read returns the stored word.
  mem_read_a: assert property (ps_rd && ps_num == 8'h00
    |=> ps_rdata == $past(st.mem_base))
    else $error("Memory base read wrong.");

  // First oscillator count reads in the low half.
  osc_read_a: assert property (ps_rd && ps_num == 8'h07
    |=> ps_rdata == {16'h0000, $past(osc_counts[15:0])})
    else $error("Oscillator count read wrong.");

  // Memory size reads with its reserved bits clear.
  cap_rsvd_a: assert property (ps_rd && ps_num == 8'h0C
    |=> ps_rdata[1:0] == 2'b00)
    else $error("Memory size reserved bits set.");

  // An unmapped number reads as zero.
  unmapped_read_a: assert property (ps_rd && ps_num == 8'h04
    |=> ps_rdata == 32'h0000_0000)
    else $error("Unmapped number read non-zero.");

  // Plain storage keeps the whole written word.
  plain_write_a: assert property (ps_wr && ps_num == 8'h05
    |=> st.plain[0] == $past(ps_wdata))
    else $error("Plain storage write lost.");

  // Reserved bit checks.

  // Vector base reserved bits never set.
  vec_base_rsvd_a: assert property (st.vec_base[17:0] == 18'h00000)
    else $error("Vector base reserved bits set.");

  // Control reserved bits never set.
  ctrl_rsvd_a: assert property ((st.ctrl & ~32'h03FF_FF36) == 32'h0000_0000)
    else $error("Control reserved bits set.");

  // Event and transmit clock checks.

  // Valid is a single pulse answering one take.
  tgt_pulse_a: assert property (!ev_take |=> !ev_target_valid)
    else $error("Target valid without a take.");

  // The target holds until the next take.
  tgt_hold_a: assert property (!ev_take |=> ev_target == $past(ev_target))
    else $error("Target changed without a take.");

  // Transmit clock rests low while the interface is off.
  txc_idle_a: assert property (!st.ctrl[8] |=> !rgmii_txc)
    else $error("Transmit clock runs while disabled.");

  // Counter never passes the divider it counts towards.
  div_range_a: assert property (rgmii_enable && st.div_cnt <= div_val
    |=> st.div_cnt <= $past(div_val))
    else $error("Divider counter out of range.");

  // A zero divider toggles the clock on every edge.
  txc_toggle_a: assert property (rgmii_enable && div_val == 9'h000
    && st.div_cnt == 9'h000 |=> rgmii_txc != $past(rgmii_txc))
    else $error("Zero divider clock did not toggle.");

  // Main scenarios.
  cov_ctrl_write_c: cover property (ps_wr && ps_num == 8'h02);
  cov_static_c: cover property (st.ctrl[4] && !st.ctrl[5] ##1 lp_div_apply);
  cov_event_c: cover property (ev_take ##1 ev_target_valid);
  cov_txc_cycle_c: cover property (rgmii_enable && !rgmii_txc ##1 rgmii_txc ##[1:20] !rgmii_txc);
  cov_dynamic_c: cover property (st.ctrl[5] && lp_div_apply ##1 !lp_div_apply);

endmodule : tsrb_bank

// ===== rtl/tsrb_pkg.sv
// Constants shared by the tile status register bank.
package tsrb_pkg;
  // Register number width seen on the status-register port.
  localparam int NUM_W = 8;
  // Register numbers of the bank.
  localparam logic [7:0] MEMORY_START_WORD = 8'h00;
  localparam logic [7:0] EVENT_VECTOR_HIGH = 8'h01;
  localparam logic [7:0] TILE_CONTROL      = 8'h02;
  localparam logic [7:0] STARTUP_STATE     = 8'h03;
  localparam logic [7:0] MEMORY_CAPACITY   = 8'h0C;
  // Plain storage registers, whose inner fields this bank does not decode.
  localparam int PLAIN_N = 19;
  localparam logic [PLAIN_N-1:0][7:0] PLAIN_NUM = {
    8'h9C, 8'h90, 8'h80, 8'h70, 8'h60, 8'h50, 8'h40, 8'h30, 8'h20, 8'h18,
    8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h06, 8'h05};
  // Ring oscillator count registers, four in a row.
  localparam logic [7:0] OSC_COUNT_FIRST = 8'h07;
  localparam logic [7:0] OSC_COUNT_LAST  = 8'h0A;
  localparam int         OSC_W           = 16;
  // Values after reset.
  localparam logic [31:0] MEM_BASE_RESET = 32'h0004_0000;
  localparam logic [31:0] VEC_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  // Writable bit masks; every other bit is reserved and reads zero.
  localparam logic [31:0] MEM_BASE_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] VEC_BASE_MASK = 32'hFFFC_0000;
  localparam logic [31:0] CTRL_MASK     = 32'h03FF_FF36;
  // Field positions inside the tile control register.
  localparam int TX_DELAY_HI  = 25;
  localparam int TX_DELAY_LO  = 18;
  localparam int TX_DIV_HI    = 17;
  localparam int TX_DIV_LO    = 9;
  localparam int RGMII_EN_BIT = 8;
  localparam int DYN_MODE_BIT = 5;
  localparam int LP_DIV_BIT   = 4;
  localparam int UTMI_SEL_BIT = 2;
  localparam int ULPI_EN_BIT  = 1;
  // Width of the transmit clock divider counter.
  localparam int DIV_W = 9;
  // Half-word split of a jump target.
  localparam int HALF_W = 16;
  // Number of hardware threads watched for the dynamic divider mode.
  localparam int THREADS = 8;
endpackage : tsrb_pkg
